// ### verilog/lssn_pkg.sv
// Constants shared by the layer-setting-services node configuration interpreter.
package lssn_pkg;
	// Frame identifiers for requests from the master and answers from the node.
	localparam logic [10:0] LSSN_ID_REQ = 11'h7E5;
	localparam logic [10:0] LSSN_ID_RSP = 11'h7E4;
	// Command specifier bytes.
	localparam logic [7:0] LSSN_CS_SWITCH = 8'h04;
	localparam logic [7:0] LSSN_CS_NODE = 8'h11;
	localparam logic [7:0] LSSN_CS_TIMING = 8'h13;
	localparam logic [7:0] LSSN_CS_ACTIVATE = 8'h15;
	localparam logic [7:0] LSSN_CS_STORE = 8'h17;
	// Mode bytes of the switch-state command.
	localparam logic [7:0] LSSN_MODE_WAIT = 8'h00;
	localparam logic [7:0] LSSN_MODE_CONFIG = 8'h01;
	// Table selector accepted by the bit timing command.
	localparam logic [7:0] LSSN_TABLE_STD = 8'h00;
	// Bit rate indexes: the reserved one and the highest legal one.
	localparam logic [3:0] LSSN_RATE_RESERVED = 4'h5;
	localparam logic [3:0] LSSN_RATE_MAX = 4'h8;
	// Factory defaults: node 127, index 4 (125 kbit/s).
	localparam logic [6:0] LSSN_NODE_DEFAULT = 7'h7F;
	localparam logic [3:0] LSSN_RATE_DEFAULT = 4'h4;
	// Answer byte meaning success.
	localparam logic [7:0] LSSN_ERR_NONE = 8'h00;
	// One delay unit is 1 ms; cycles per unit at 250 MHz (4 ns).
	localparam int LSSN_UNIT_NS = 1000000;
	localparam int LSSN_CLK_NS = 4;
	localparam int LSSN_UNIT_CYC = LSSN_UNIT_NS / LSSN_CLK_NS;
	// Interpreter states.
	typedef enum logic [1:0] {
		LSSN_WAITING = 2'b00,
		LSSN_CONFIG = 2'b01,
		LSSN_SWITCH = 2'b10,
		LSSN_HOLD = 2'b11
	} lssn_state_t;
endpackage

// ### verilog/lssn_node.sv
// Layer-setting-services slave that sets node identifier and bit rate.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Factory node 127 and 125 kbit/s.
// - Identifier and rate change only via these services.
// - Switch to waiting resets node to pre-operational.
// - Node identifier answer is 0x11 0x00 0x00.
// - Store saves configuration, answers 0x17 0x00 0x00.
// - Decode rate index table zero to eight; the code refuses index 5 as reserved.
// - Activate waits delay, switches, waits again.
module lssn_node
	import lssn_pkg::*;
#(
	// Cycles in one 1 ms delay unit; shorten for simulation.
	parameter int UNIT_CYC = LSSN_UNIT_CYC
) (
	input wire logic sys_clk,
	input wire logic resetn,
	// Received frame from the CAN controller, one-cycle strobe.
	input wire logic rx_valid,
	input wire logic [10:0] rx_id,
	input wire logic [3:0] rx_len,
	input wire logic [7:0] rx_d0,
	input wire logic [7:0] rx_d1,
	input wire logic [7:0] rx_d2,
	// Stored settings read from non-volatile storage, loaded at reset release.
	input wire logic [6:0] nv_node,
	input wire logic [3:0] nv_rate,
	input wire logic nv_valid,
	// Answer frame to the CAN controller, held until accepted.
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [10:0] tx_id,
	output logic [3:0] tx_len,
	output logic [7:0] tx_d0,
	output logic [7:0] tx_d1,
	output logic [7:0] tx_d2,
	// Active node identifier and bit rate index.
	output logic [6:0] node_id,
	output logic [3:0] rate_idx,
	// Controller must stay silent while high.
	output logic tx_inhibit,
	// Write of the pending settings into non-volatile storage, one pulse.
	output logic nv_write,
	output logic [6:0] nv_wr_node,
	output logic [3:0] nv_wr_rate,
	// Node restart request toward pre-operational, one pulse.
	output logic node_restart
);
	lssn_state_t state_ff; // Interpreter state.
	logic [6:0] node_ff; // Active node identifier.
	logic [3:0] rate_ff; // Active rate index.
	logic [6:0] pend_node_ff; // Node identifier awaiting store.
	logic [3:0] pend_rate_ff; // Rate index awaiting activation.
	logic [15:0] delay_ff; // Delay in ms from the activate command.
	logic [15:0] ms_ff; // Remaining ms of the current period.
	logic [31:0] sub_ff; // Cycles inside the current ms.
	logic loaded_ff; // Stored settings were taken once.
	logic tx_valid_ff;
	logic [7:0] tx_d0_ff;
	logic nv_write_ff;
	logic restart_ff;
	logic is_req; // A request frame for this service.
	logic in_cfg; // Configuring commands are allowed.
	logic do_node, do_rate, do_store, do_act, do_leave, do_enter;
	logic ms_tick; // End of one ms.

	assign is_req = rx_valid && (rx_id == LSSN_ID_REQ);
	assign in_cfg = (state_ff == LSSN_CONFIG);
	assign do_enter = is_req && rx_len == 4'd2 && rx_d0 == LSSN_CS_SWITCH
		&& rx_d1 == LSSN_MODE_CONFIG;
	assign do_leave = is_req && rx_len == 4'd2 && rx_d0 == LSSN_CS_SWITCH
		&& rx_d1 == LSSN_MODE_WAIT;
	// Node identifiers 1 to 127 only; zero is not a node.
	assign do_node = is_req && in_cfg && rx_len == 4'd2 && rx_d0 == LSSN_CS_NODE
		&& rx_d1 != 8'h00 && rx_d1[7] == 1'b0;
	assign do_rate = is_req && in_cfg && rx_len == 4'd3 && rx_d0 == LSSN_CS_TIMING
		&& rx_d1 == LSSN_TABLE_STD && rx_d2[7:4] == 4'h0
		&& rx_d2[3:0] <= LSSN_RATE_MAX && rx_d2[3:0] != LSSN_RATE_RESERVED;
	assign do_store = is_req && in_cfg && rx_len == 4'd1 && rx_d0 == LSSN_CS_STORE;
	assign do_act = is_req && in_cfg && rx_len == 4'd3 && rx_d0 == LSSN_CS_ACTIVATE;
	assign ms_tick = (sub_ff == 32'(UNIT_CYC - 1));

	// State sequence; a leave request wins over everything but a running switch or hold period.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_ff <= LSSN_WAITING;
		end else begin
			case (state_ff)
				LSSN_WAITING: begin
					if (do_enter) begin
						state_ff <= LSSN_CONFIG;
					end
				end
				LSSN_CONFIG: begin
					if (do_leave) begin
						state_ff <= LSSN_WAITING;
					end else if (do_act) begin
						state_ff <= LSSN_SWITCH;
					end
				end
				LSSN_SWITCH: begin
					if (ms_tick && ms_ff <= 16'd1) begin
						state_ff <= LSSN_HOLD;
					end
				end
				LSSN_HOLD: begin
					if (ms_tick && ms_ff <= 16'd1) begin
						state_ff <= LSSN_CONFIG;
					end
				end
				default: begin
					state_ff <= LSSN_WAITING;
				end
			endcase
		end
	end

	// Millisecond timer; a zero delay still costs one ms per period.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			sub_ff <= 32'h0000_0000;
			ms_ff <= 16'h0000;
			delay_ff <= 16'h0000;
		end else if (state_ff == LSSN_CONFIG && do_act && !do_leave) begin
			delay_ff <= {rx_d2, rx_d1};
			ms_ff <= {rx_d2, rx_d1};
			sub_ff <= 32'h0000_0000;
		end else if (state_ff == LSSN_SWITCH || state_ff == LSSN_HOLD) begin
			sub_ff <= ms_tick ? 32'h0000_0000 : sub_ff + 32'h0000_0001;
			if (ms_tick) begin
				ms_ff <= (ms_ff <= 16'd1) ? delay_ff : ms_ff - 16'h0001;
			end
		end
	end

	// Active and pending settings; defaults first, stored values once loaded.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			node_ff <= LSSN_NODE_DEFAULT;
			rate_ff <= LSSN_RATE_DEFAULT;
			pend_node_ff <= LSSN_NODE_DEFAULT;
			pend_rate_ff <= LSSN_RATE_DEFAULT;
			loaded_ff <= 1'b0;
		end else if (!loaded_ff) begin
			// Stored settings are sampled once after release, never held in reset.
			loaded_ff <= 1'b1;
			if (nv_valid) begin
				node_ff <= nv_node;
				rate_ff <= nv_rate;
				pend_node_ff <= nv_node;
				pend_rate_ff <= nv_rate;
			end
		end else begin
			if (do_node) begin
				pend_node_ff <= rx_d1[6:0];
			end
			if (do_rate) begin
				pend_rate_ff <= rx_d2[3:0];
			end
			if (state_ff == LSSN_SWITCH && ms_tick && ms_ff <= 16'd1) begin
				rate_ff <= pend_rate_ff;
			end
		end
	end

	// Answers: node, timing and store commands each get one three-byte frame.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			tx_valid_ff <= 1'b0;
			tx_d0_ff <= 8'h00;
		end else if (do_node || do_rate || do_store) begin
			tx_valid_ff <= 1'b1;
			tx_d0_ff <= rx_d0;
		end else if (tx_ready) begin
			tx_valid_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			nv_write_ff <= 1'b0;
		end else begin
			nv_write_ff <= do_store;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			restart_ff <= 1'b0;
		end else begin
			restart_ff <= do_leave && (state_ff == LSSN_CONFIG);
		end
	end

	assign tx_valid = tx_valid_ff;
	assign tx_id = LSSN_ID_RSP;
	assign tx_len = 4'd3;
	assign tx_d0 = tx_d0_ff;
	assign tx_d1 = LSSN_ERR_NONE;
	assign tx_d2 = LSSN_ERR_NONE;
	// The node identifier stays the default or stored one; the pending one only goes to storage.
	assign node_id = node_ff;
	assign rate_idx = rate_ff;
	assign tx_inhibit = (state_ff == LSSN_SWITCH) || (state_ff == LSSN_HOLD);
	assign nv_write = nv_write_ff;
	assign nv_wr_node = pend_node_ff;
	assign nv_wr_rate = pend_rate_ff;
	assign node_restart = restart_ff;

	chk_ignore_outside: assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_req && state_ff == LSSN_WAITING && loaded_ff) |=> !tx_valid || $past(tx_valid))
		else $error("answer given outside configuration state");
	chk_node_answer: assert property (@(posedge sys_clk) disable iff (!resetn)
		do_node |=> tx_valid && tx_d0 == LSSN_CS_NODE && tx_d1 == 8'h00)
		else $error("node identifier answer wrong");
	chk_store_write: assert property (@(posedge sys_clk) disable iff (!resetn)
		do_store |=> nv_write && tx_valid && tx_d0 == LSSN_CS_STORE)
		else $error("store not written or answered");
	chk_leave_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
		(do_leave && state_ff == LSSN_CONFIG) |=> node_restart && state_ff == LSSN_WAITING)
		else $error("leave did not restart node");
	chk_switch_silent: assert property (@(posedge sys_clk) disable iff (!resetn)
		(state_ff == LSSN_CONFIG && do_act && !do_leave) |=> tx_inhibit [*2])
		else $error("transmit not inhibited during switch");
	chk_rate_stable: assert property (@(posedge sys_clk) disable iff (!resetn)
		(loaded_ff && $past(loaded_ff) && $past(state_ff) != LSSN_SWITCH) |-> $stable(rate_idx))
		else $error("rate changed outside switch");
	chk_rate_reserved: assert property (@(posedge sys_clk) disable iff (!resetn)
		(is_req && rx_d0 == LSSN_CS_TIMING && rx_d2 == 8'h05) |-> !do_rate)
		else $error("reserved rate index accepted");
	chk_reset_default: assert property (@(posedge sys_clk)
		!resetn |=> node_id == LSSN_NODE_DEFAULT && rate_idx == LSSN_RATE_DEFAULT)
		else $error("factory defaults missing after reset");
endmodule
`default_nettype wire

// ### test/lssn_master_model.sv
// Model of the configuration master that sends requests and accepts answers.
`timescale 1ns/1ps
`default_nettype none
module lssn_master_model
	import lssn_pkg::*;
(
	input wire logic sys_clk,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic rx_valid,
	output logic [10:0] rx_id,
	output logic [3:0] rx_len,
	output logic [7:0] rx_d0,
	output logic [7:0] rx_d1,
	output logic [7:0] rx_d2
);
	// When set, the master is slow and leaves the pending answer waiting.
	logic stall = 1'b0;
	assign tx_ready = ~stall;
	initial begin
		rx_valid = 1'b0;
		rx_id = 11'h000;
		rx_len = 4'h0;
		{rx_d0, rx_d1, rx_d2} = 24'h00_0000;
	end
	// Request frames on identifier.
	// Identifier and data bytes are inverted once the strobe drops, so stale values cannot pass as a frame.
	task automatic send(input logic [3:0] len, input logic [7:0] b0, b1, b2);
		@(negedge sys_clk);
		rx_valid = 1'b1;
		rx_id = LSSN_ID_REQ;
		rx_len = len;
		{rx_d0, rx_d1, rx_d2} = {b0, b1, b2};
		@(negedge sys_clk);
		rx_valid = 1'b0;
		rx_id = ~rx_id;
		{rx_d0, rx_d1, rx_d2} = ~{b0, b1, b2};
	endtask
endmodule
`default_nettype wire

// ### test/test_lssn_node.sv
// Self-checking bench for the node configuration interpreter.
`timescale 1ns/1ps
`default_nettype none
module test_lssn_node;
	import lssn_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic rx_valid, tx_valid, tx_ready, tx_inhibit, nv_write, node_restart;
	logic [10:0] rx_id, tx_id;
	logic [3:0] rx_len, tx_len, rate_idx, nv_wr_rate;
	logic [7:0] rx_d0, rx_d1, rx_d2, tx_d0, tx_d1, tx_d2;
	logic [6:0] node_id, nv_wr_node;
	// Stored settings offered at reset release; a mid-run reset reloads them.
	logic [6:0] nv_node = 7'h00;
	logic [3:0] nv_rate = 4'h0;
	logic nv_valid = 1'b0;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	// Half period of 2 ns gives the 250 MHz system clock.
	always #2 sys_clk = ~sys_clk;
	lssn_master_model i_master (.sys_clk(sys_clk), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_id(rx_id), .rx_len(rx_len), .rx_d0(rx_d0), .rx_d1(rx_d1),
		.rx_d2(rx_d2));
	// A short delay unit keeps the activation periods to a few cycles.
	lssn_node #(.UNIT_CYC(4)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .rx_valid(rx_valid),
		.rx_id(rx_id), .rx_len(rx_len), .rx_d0(rx_d0), .rx_d1(rx_d1), .rx_d2(rx_d2),
		.nv_node(nv_node), .nv_rate(nv_rate), .nv_valid(nv_valid), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_id(tx_id), .tx_len(tx_len), .tx_d0(tx_d0), .tx_d1(tx_d1),
		.tx_d2(tx_d2), .node_id(node_id), .rate_idx(rate_idx), .tx_inhibit(tx_inhibit),
		.nv_write(nv_write), .nv_wr_node(nv_wr_node), .nv_wr_rate(nv_wr_rate),
		.node_restart(node_restart));
	// Wide enough for a whole three-byte answer, so the echoed command byte is compared too.
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("tests=%0d errors=%0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Expect a full success answer for the given command byte.
	task automatic expect_answer(input logic [7:0] cmd);
		check(tx_valid, 1'b1);
		check({tx_id, tx_len}, {LSSN_ID_RSP, 4'h3});
		check({tx_d0, tx_d1, tx_d2}, {cmd, 16'h0000});
	endtask
	task automatic t_defaults();
		check({node_id, rate_idx}, {7'h7F, 4'h4});
		check({tx_valid, tx_inhibit}, 2'b00);
	endtask
	task automatic t_outside();
		i_master.send(4'h2, LSSN_CS_NODE, 8'h05, 8'h00);
		i_master.send(4'h1, LSSN_CS_STORE, 8'h00, 8'h00);
		@(negedge sys_clk);
		check({tx_valid, nv_write}, 2'b00);
	endtask
	task automatic t_node();
		i_master.send(4'h2, LSSN_CS_SWITCH, LSSN_MODE_CONFIG, 8'h00);
		i_master.send(4'h2, LSSN_CS_NODE, 8'h00, 8'h00);
		@(negedge sys_clk);
		check(tx_valid, 1'b0);
		i_master.stall = 1'b1;
		i_master.send(4'h2, LSSN_CS_NODE, 8'h05, 8'h00);
		repeat (4) @(negedge sys_clk);
		expect_answer(LSSN_CS_NODE);
		i_master.stall = 1'b0;
		repeat (2) @(negedge sys_clk);
		check(tx_valid, 1'b0);
	endtask
	task automatic t_rate();
		i_master.send(4'h3, LSSN_CS_TIMING, 8'h00, {4'h0, LSSN_RATE_RESERVED});
		i_master.send(4'h3, LSSN_CS_TIMING, 8'h01, 8'h03);
		@(negedge sys_clk);
		check(tx_valid, 1'b0);
		i_master.send(4'h3, LSSN_CS_TIMING, LSSN_TABLE_STD, 8'h03);
		// The answer stands only until the next edge with ready high, so look now.
		expect_answer(LSSN_CS_TIMING);
		i_master.send(4'h3, LSSN_CS_ACTIVATE, 8'h02, 8'h00);
		@(negedge sys_clk);
		check({tx_inhibit, rate_idx}, {1'b1, 4'h4});
		repeat (5) @(negedge sys_clk);
		check({tx_inhibit, rate_idx}, {1'b1, 4'h4});
		repeat (6) @(negedge sys_clk);
		check({tx_inhibit, rate_idx}, {1'b1, 4'h3});
		repeat (10) @(negedge sys_clk);
		check(tx_inhibit, 1'b0);
	endtask
	task automatic t_store_leave();
		// Store is sent only after the new rate is active.
		i_master.send(4'h1, LSSN_CS_STORE, 8'h00, 8'h00);
		// Answer and write pulse are both up for one cycle after the request edge.
		expect_answer(LSSN_CS_STORE);
		check({nv_write, nv_wr_node, nv_wr_rate}, {1'b1, 7'h05, 4'h3});
		@(negedge sys_clk);
		check(nv_write, 1'b0);
		i_master.send(4'h2, LSSN_CS_SWITCH, LSSN_MODE_WAIT, 8'h00);
		// The restart pulse lasts one cycle, so it is sampled right after the request edge.
		check({node_restart, node_id}, {1'b1, 7'h7F});
		i_master.send(4'h2, LSSN_CS_NODE, 8'h09, 8'h00);
		@(negedge sys_clk);
		check({node_restart, tx_valid}, 2'b00);
	endtask
	// Mid-run reset: defaults while held, the stored values taken at release.
	task automatic t_reload();
		@(negedge sys_clk);
		resetn = 1'b0;
		nv_node = 7'h05;
		nv_rate = 4'h3;
		nv_valid = 1'b1;
		repeat (2) @(negedge sys_clk);
		check({node_id, rate_idx, node_restart}, {7'h7F, 4'h4, 1'b0});
		resetn = 1'b1;
		@(negedge sys_clk);
		check({node_id, rate_idx, tx_inhibit}, {7'h05, 4'h3, 1'b0});
	endtask
	// The whole run needs about 85 cycles, so 2000 means a hang.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (20) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (2) @(negedge sys_clk);
		t_defaults();
		t_outside();
		t_node();
		t_rate();
		t_store_leave();
		t_reload();
		report_and_stop();
	end
endmodule
`default_nettype wire
